/* verilog/lan_regs_pkg.sv */
// Purpose: Constants, types and decode helpers for the lock alarm / NVM control register slice
// Assumes: Register offsets are word indices; byte address on the bus is four times the index
// Notes: Page number is index bits 15:8, offset within the page is bits 7:0
package lan_regs_pkg;

	// ========================================
	// Bus geometry
	localparam int ADDR_W = 18;
	localparam int IDX_W = 16;

	// ========================================
	// Register indices
	localparam logic [15:0] IDX_SET_LEVEL = 16'h009E;
	localparam logic [15:0] IDX_CLEAR_LEVEL = 16'h00A0;
	localparam logic [15:0] IDX_TIMER_CTL = 16'h00A2;
	localparam logic [15:0] IDX_CLR_DELAY_LO = 16'h00A9;
	localparam logic [15:0] IDX_WRITE_COUNT = 16'h00E2;
	localparam logic [15:0] IDX_BURN_CMD = 16'h00E3;
	localparam logic [15:0] IDX_RELOAD = 16'h00E4;
	localparam logic [15:0] IDX_EXTEND_CTL = 16'h00E5;
	localparam logic [15:0] IDX_EXTEND_LO = 16'h00EA;
	localparam logic [15:0] IDX_FLAG_SUMMARY = 16'h00F6;
	localparam logic [15:0] IDX_SYS_FLAGS = 16'h00F7;
	localparam logic [15:0] IDX_INP_FLAGS = 16'h00F8;
	localparam logic [15:0] IDX_PLL_FLAGS = 16'h00F9;
	localparam logic [7:0] PAGE_OFS_READY = 8'hFE;
	localparam logic [15:0] IDX_OUT_GATE = 16'h0102;

	// ========================================
	// Field positions, codes and reset values
	localparam int LEVEL_LSB = 4;
	localparam int TIMER_EN_BIT = 1;
	localparam int RELOAD_BIT = 0;
	localparam int EXTEND_EN_BIT = 5;
	localparam int GATE_BIT = 0;
	localparam int WIDE_BYTES = 4;
	localparam logic [31:0] WIDE_MASK = 32'h1FFF_FFFF;
	localparam logic [7:0] BURN_KEY = 8'hC7;
	localparam logic [7:0] READY_CODE = 8'h0F;
	localparam logic [7:0] NOT_READY_CODE = 8'h00;
	localparam logic [1:0] WRITE_COUNT_MAX = 2'h3;
	localparam logic [7:0] SYS_FLAG_MASK = 8'h37;
	localparam logic [7:0] INP_FLAG_MASK = 8'hFF;
	localparam logic [7:0] PLL_FLAG_MASK = 8'h22;
	localparam logic [3:0] RST_LEVEL = 4'h0;
	localparam logic [7:0] RST_BURN_CMD = 8'h00;
	localparam logic RST_TIMER_EN = 1'b0;
	localparam logic RST_EXTEND_EN = 1'b1;
	localparam logic RST_GATE = 1'b1;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ========================================
	// Types
	typedef enum logic [1:0] {
		LAN_NVM_IDLE = 2'b00,
		LAN_NVM_BURN = 2'b01,
		LAN_NVM_RELOAD = 2'b10
	} lan_nvm_state_t;

	typedef struct packed {
		logic [16:0] setTenthsPpm;
		logic setValid;
		logic [16:0] clearTenthsPpm;
		logic clearValid;
		logic timerOn;
		logic [28:0] clearDelay;
		logic extendOn;
		logic [28:0] extendLen;
	} lan_cfg_t;

	typedef struct packed {
		logic [7:0] sys;
		logic [7:0] inp;
		logic [7:0] pll;
	} lan_alarm_t;

	// ========================================
	// Threshold ladder in tenths of a ppm; codes above 10 give zero
	function automatic logic [16:0] lan_ppm_tenths(input logic [3:0] code);
		case (code)
			4'h0: lan_ppm_tenths = 17'h00001;
			4'h1: lan_ppm_tenths = 17'h00003;
			4'h2: lan_ppm_tenths = 17'h0000A;
			4'h3: lan_ppm_tenths = 17'h0001E;
			4'h4: lan_ppm_tenths = 17'h00064;
			4'h5: lan_ppm_tenths = 17'h0012C;
			4'h6: lan_ppm_tenths = 17'h003E8;
			4'h7: lan_ppm_tenths = 17'h00BB8;
			4'h8: lan_ppm_tenths = 17'h02710;
			4'h9: lan_ppm_tenths = 17'h07530;
			4'hA: lan_ppm_tenths = 17'h186A0;
			default: lan_ppm_tenths = 17'h00000;
		endcase
	endfunction : lan_ppm_tenths

	function automatic logic [7:0] lan_count_code(input logic [1:0] cnt);
		case (cnt)
			2'h0: lan_count_code = 8'h00;
			2'h1: lan_count_code = 8'h03;
			2'h2: lan_count_code = 8'h0F;
			default: lan_count_code = 8'h3F;
		endcase
	endfunction : lan_count_code

endpackage : lan_regs_pkg

/* verilog/lan_ctrl_regs.sv */
// Purpose: AXI4-Lite register slice for lock-loss thresholds, NVM burn/reload, fastlock extension,
//   alarm flag groups, device ready byte and the global output gate
// Assumes: Flag events, NVM done pulses and output enables come from logic on clk_sys
// Notes: Single-byte registers sit in bits 7:0 of each word; upper bits read zero
// Contract
// - The set-level code in bits 7:4 at 0x009E decodes 0..10 to 0.1 through 10000 ppm.
// - The clear-level code in bits 7:4 at 0x00A0 decodes with the same ladder.
// - Bit 1 at 0x00A2 turns the lock-loss timer on when 1 and off when 0.
// - The byte at 0x00E2 reads 0, 3, 15 or 63 for zero to three bank writes done.
// - Writing 0xC7 to 0x00E3 starts a burn of the non-volatile bank.
// - Setting bit 0 at 0x00E4 copies non-volatile contents into volatile storage.
// - Bit 5 at 0x00E5 extends fastlock past lock-loss clear when 1 (default) or not when 0.
// - The fastlock extension length is 29 bits over four bytes from 0x00EA, top byte 28:24.
// - The ready byte at 0x00FE reads 0x0F once ready, and software waits for it.
// - The ready byte reads at offset 0xFE of every page.
// - Bit 0 at 0x0102 passes output enables through when 1 and kills all outputs when 0.
module lan_ctrl_regs #(
	parameter int NUM_OUT = 10
) (
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic [lan_regs_pkg::ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [lan_regs_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire lan_regs_pkg::lan_alarm_t alarmEvent,
	input wire logic burnDone,
	input wire logic reloadDone,
	input wire logic [NUM_OUT-1:0] outEnReq,
	output lan_regs_pkg::lan_cfg_t cfgOut,
	output logic burnStart,
	output logic reloadStart,
	output logic [NUM_OUT-1:0] outEnGated
);

	// ========================================
	// Write channel capture: address and data taken in either order
	logic awHeld_ff;
	logic [lan_regs_pkg::IDX_W-1:0] awIdx_ff;
	logic wHeld_ff;
	logic [7:0] wByte_ff;
	logic wLane0_ff;
	logic bvalid_ff;
	logic [1:0] bresp_ff;
	logic wrTake;
	logic wrEn;
	logic [lan_regs_pkg::IDX_W-1:0] wrIdx;
	logic [7:0] wrByte;

	assign s_axi_awready = !awHeld_ff;
	assign s_axi_wready = !wHeld_ff;
	assign s_axi_bvalid = bvalid_ff;
	assign s_axi_bresp = bresp_ff;
	assign wrTake = awHeld_ff && wHeld_ff && !bvalid_ff;
	assign wrIdx = awIdx_ff;
	assign wrByte = wByte_ff;
	// A write with lane 0 disabled is answered but stores nothing
	assign wrEn = wrTake && wLane0_ff && isWritable(awIdx_ff);

	function automatic logic isWritable(input logic [lan_regs_pkg::IDX_W-1:0] idx);
		isWritable = (idx == lan_regs_pkg::IDX_SET_LEVEL) || (idx == lan_regs_pkg::IDX_CLEAR_LEVEL)
			|| (idx == lan_regs_pkg::IDX_TIMER_CTL) || (idx == lan_regs_pkg::IDX_BURN_CMD)
			|| (idx == lan_regs_pkg::IDX_RELOAD) || (idx == lan_regs_pkg::IDX_EXTEND_CTL)
			|| (idx == lan_regs_pkg::IDX_OUT_GATE)
			|| (idx >= lan_regs_pkg::IDX_CLR_DELAY_LO && idx < lan_regs_pkg::IDX_CLR_DELAY_LO + 16'h0004)
			|| (idx >= lan_regs_pkg::IDX_EXTEND_LO && idx < lan_regs_pkg::IDX_EXTEND_LO + 16'h0004);
	endfunction : isWritable

	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			awHeld_ff <= 1'b0;
			awIdx_ff <= '0;
		end else if (s_axi_awvalid && !awHeld_ff) begin
			awHeld_ff <= 1'b1;
			awIdx_ff <= s_axi_awaddr[lan_regs_pkg::ADDR_W-1:2];
		end else if (wrTake) begin
			awHeld_ff <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			wHeld_ff <= 1'b0;
			wByte_ff <= 8'h00;
			wLane0_ff <= 1'b0;
		end else if (s_axi_wvalid && !wHeld_ff) begin
			wHeld_ff <= 1'b1;
			wByte_ff <= s_axi_wdata[7:0];
			wLane0_ff <= s_axi_wstrb[0];
		end else if (wrTake) begin
			wHeld_ff <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			bvalid_ff <= 1'b0;
			bresp_ff <= lan_regs_pkg::RESP_OKAY;
		end else if (wrTake) begin
			bvalid_ff <= 1'b1;
			bresp_ff <= isWritable(awIdx_ff) ? lan_regs_pkg::RESP_OKAY : lan_regs_pkg::RESP_SLVERR;
		end else if (s_axi_bready) begin
			bvalid_ff <= 1'b0;
		end
	end

	// ========================================
	// Configuration registers
	logic [3:0] setLevel_ff;
	logic [3:0] clearLevel_ff;
	logic timerOn_ff;
	logic [31:0] clearDelay_ff;
	logic [31:0] nxt_clearDelay;
	logic [7:0] burnCmd_ff;
	logic extendOn_ff;
	logic [31:0] extendLen_ff;
	logic [31:0] nxt_extendLen;
	logic gate_ff;

	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			setLevel_ff <= lan_regs_pkg::RST_LEVEL;
			clearLevel_ff <= lan_regs_pkg::RST_LEVEL;
			timerOn_ff <= lan_regs_pkg::RST_TIMER_EN;
			burnCmd_ff <= lan_regs_pkg::RST_BURN_CMD;
			extendOn_ff <= lan_regs_pkg::RST_EXTEND_EN;
			gate_ff <= lan_regs_pkg::RST_GATE;
		end else if (wrEn) begin
			case (wrIdx)
				lan_regs_pkg::IDX_SET_LEVEL: setLevel_ff <= wrByte[7:4];
				lan_regs_pkg::IDX_CLEAR_LEVEL: clearLevel_ff <= wrByte[7:4];
				lan_regs_pkg::IDX_TIMER_CTL: timerOn_ff <= wrByte[lan_regs_pkg::TIMER_EN_BIT];
				lan_regs_pkg::IDX_BURN_CMD: burnCmd_ff <= wrByte;
				lan_regs_pkg::IDX_EXTEND_CTL: extendOn_ff <= wrByte[lan_regs_pkg::EXTEND_EN_BIT];
				lan_regs_pkg::IDX_OUT_GATE: gate_ff <= wrByte[lan_regs_pkg::GATE_BIT];
				default: ;
			endcase
		end
	end

	// Wide fields: bytes land in order of index, bits above 28 never store
	always_comb begin
		nxt_clearDelay = clearDelay_ff;
		nxt_extendLen = extendLen_ff;
		for (int k = 0; k < lan_regs_pkg::WIDE_BYTES; k++) begin
			if (wrEn && wrIdx == lan_regs_pkg::IDX_CLR_DELAY_LO + 16'(k)) begin
				nxt_clearDelay[k*8 +: 8] = wrByte;
			end
			if (wrEn && wrIdx == lan_regs_pkg::IDX_EXTEND_LO + 16'(k)) begin
				nxt_extendLen[k*8 +: 8] = wrByte;
			end
		end
		nxt_clearDelay = nxt_clearDelay & lan_regs_pkg::WIDE_MASK;
		nxt_extendLen = nxt_extendLen & lan_regs_pkg::WIDE_MASK;
	end

	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			clearDelay_ff <= 32'h0000_0000;
			extendLen_ff <= 32'h0000_0000;
		end else begin
			clearDelay_ff <= nxt_clearDelay;
			extendLen_ff <= nxt_extendLen;
		end
	end

	// ========================================
	// Decoded configuration and gated output enables
	lan_regs_pkg::lan_cfg_t cfg_ff;
	logic [NUM_OUT-1:0] outEn_ff;

	assign cfgOut = cfg_ff;
	assign outEnGated = outEn_ff;

	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			cfg_ff <= '0;
		end else begin
			cfg_ff.setTenthsPpm <= lan_regs_pkg::lan_ppm_tenths(setLevel_ff);
			cfg_ff.setValid <= (setLevel_ff <= 4'hA);
			cfg_ff.clearTenthsPpm <= lan_regs_pkg::lan_ppm_tenths(clearLevel_ff);
			cfg_ff.clearValid <= (clearLevel_ff <= 4'hA);
			cfg_ff.timerOn <= timerOn_ff;
			cfg_ff.clearDelay <= clearDelay_ff[28:0];
			cfg_ff.extendOn <= extendOn_ff;
			cfg_ff.extendLen <= extendLen_ff[28:0];
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			outEn_ff <= '0;
		end else begin
			outEn_ff <= outEnReq & {NUM_OUT{gate_ff}};
		end
	end

	// ========================================
	// NVM sequencing; a reload runs from reset so the ready byte waits for it
	lan_regs_pkg::lan_nvm_state_t nvmState_ff;
	logic burnStart_ff;
	logic reloadStart_ff;
	logic [1:0] writeCount_ff;
	logic burnReq;
	logic reloadReq;
	logic [7:0] readyByte;

	assign burnStart = burnStart_ff;
	assign reloadStart = reloadStart_ff;
	assign burnReq = wrEn && wrIdx == lan_regs_pkg::IDX_BURN_CMD && wrByte == lan_regs_pkg::BURN_KEY;
	assign reloadReq = wrEn && wrIdx == lan_regs_pkg::IDX_RELOAD && wrByte[lan_regs_pkg::RELOAD_BIT];
	assign readyByte = (nvmState_ff == lan_regs_pkg::LAN_NVM_IDLE) ?
		lan_regs_pkg::READY_CODE : lan_regs_pkg::NOT_READY_CODE;

	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			nvmState_ff <= lan_regs_pkg::LAN_NVM_RELOAD;
			burnStart_ff <= 1'b0;
			reloadStart_ff <= 1'b1;
		end else begin
			burnStart_ff <= 1'b0;
			reloadStart_ff <= 1'b0;
			case (nvmState_ff)
				// Requests while busy are dropped: NVM cannot queue a second operation
				lan_regs_pkg::LAN_NVM_IDLE: begin
					if (burnReq) begin
						nvmState_ff <= lan_regs_pkg::LAN_NVM_BURN;
						burnStart_ff <= 1'b1;
					end else if (reloadReq) begin
						nvmState_ff <= lan_regs_pkg::LAN_NVM_RELOAD;
						reloadStart_ff <= 1'b1;
					end
				end
				lan_regs_pkg::LAN_NVM_BURN: begin
					if (burnDone) begin
						nvmState_ff <= lan_regs_pkg::LAN_NVM_IDLE;
					end
				end
				lan_regs_pkg::LAN_NVM_RELOAD: begin
					if (reloadDone) begin
						nvmState_ff <= lan_regs_pkg::LAN_NVM_IDLE;
					end
				end
				default: nvmState_ff <= lan_regs_pkg::LAN_NVM_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			writeCount_ff <= 2'h0;
		end else if (nvmState_ff == lan_regs_pkg::LAN_NVM_BURN && burnDone
			&& writeCount_ff != lan_regs_pkg::WRITE_COUNT_MAX) begin
			writeCount_ff <= writeCount_ff + 2'h1;
		end
	end

	// ========================================
	// Sticky alarm flags, cleared by reading their register; a new event wins
	lan_regs_pkg::lan_alarm_t flags_ff;
	lan_regs_pkg::lan_alarm_t flagClr;
	logic [2:0] summary;
	logic rdTake;
	logic [lan_regs_pkg::IDX_W-1:0] rdIdx;

	assign rdTake = s_axi_arvalid && !s_axi_rvalid;
	assign rdIdx = s_axi_araddr[lan_regs_pkg::ADDR_W-1:2];
	assign flagClr.sys = {8{rdTake && rdIdx == lan_regs_pkg::IDX_SYS_FLAGS}};
	assign flagClr.inp = {8{rdTake && rdIdx == lan_regs_pkg::IDX_INP_FLAGS}};
	assign flagClr.pll = {8{rdTake && rdIdx == lan_regs_pkg::IDX_PLL_FLAGS}};
	assign summary = {|flags_ff.pll, |flags_ff.inp, |flags_ff.sys};

	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			flags_ff <= '0;
		end else begin
			flags_ff.sys <= ((flags_ff.sys & ~flagClr.sys) | alarmEvent.sys) & lan_regs_pkg::SYS_FLAG_MASK;
			flags_ff.inp <= ((flags_ff.inp & ~flagClr.inp) | alarmEvent.inp) & lan_regs_pkg::INP_FLAG_MASK;
			flags_ff.pll <= ((flags_ff.pll & ~flagClr.pll) | alarmEvent.pll) & lan_regs_pkg::PLL_FLAG_MASK;
		end
	end

	// ========================================
	// Read channel
	logic rvalid_ff;
	logic [31:0] rdata_ff;
	logic [1:0] rresp_ff;
	logic [7:0] rdByte;
	logic rdHit;

	assign s_axi_arready = !rvalid_ff;
	assign s_axi_rvalid = rvalid_ff;
	assign s_axi_rdata = rdata_ff;
	assign s_axi_rresp = rresp_ff;

	always_comb begin
		rdByte = 8'h00;
		rdHit = 1'b1;
		if (rdIdx[7:0] == lan_regs_pkg::PAGE_OFS_READY) begin
			rdByte = readyByte;
		end else if (rdIdx >= lan_regs_pkg::IDX_CLR_DELAY_LO
			&& rdIdx < lan_regs_pkg::IDX_CLR_DELAY_LO + 16'h0004) begin
			rdByte = clearDelay_ff[
				{2'(rdIdx[1:0] - lan_regs_pkg::IDX_CLR_DELAY_LO[1:0]), 3'h0} +: 8];
		end else if (rdIdx >= lan_regs_pkg::IDX_EXTEND_LO
			&& rdIdx < lan_regs_pkg::IDX_EXTEND_LO + 16'h0004) begin
			rdByte = extendLen_ff[
				{2'(rdIdx[1:0] - lan_regs_pkg::IDX_EXTEND_LO[1:0]), 3'h0} +: 8];
		end else begin
			case (rdIdx)
				lan_regs_pkg::IDX_SET_LEVEL: rdByte = {setLevel_ff, 4'h0};
				lan_regs_pkg::IDX_CLEAR_LEVEL: rdByte = {clearLevel_ff, 4'h0};
				lan_regs_pkg::IDX_TIMER_CTL: rdByte = {6'h00, timerOn_ff, 1'b0};
				lan_regs_pkg::IDX_WRITE_COUNT: rdByte = lan_regs_pkg::lan_count_code(writeCount_ff);
				lan_regs_pkg::IDX_BURN_CMD: rdByte = burnCmd_ff;
				lan_regs_pkg::IDX_RELOAD: rdByte = {7'h00, nvmState_ff == lan_regs_pkg::LAN_NVM_RELOAD};
				lan_regs_pkg::IDX_EXTEND_CTL: rdByte = {2'h0, extendOn_ff, 5'h00};
				lan_regs_pkg::IDX_FLAG_SUMMARY: rdByte = {5'h00, summary};
				lan_regs_pkg::IDX_SYS_FLAGS: rdByte = flags_ff.sys;
				lan_regs_pkg::IDX_INP_FLAGS: rdByte = flags_ff.inp;
				lan_regs_pkg::IDX_PLL_FLAGS: rdByte = flags_ff.pll;
				lan_regs_pkg::IDX_OUT_GATE: rdByte = {7'h00, gate_ff};
				default: rdHit = 1'b0;
			endcase
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			rvalid_ff <= 1'b0;
			rdata_ff <= 32'h0000_0000;
			rresp_ff <= lan_regs_pkg::RESP_OKAY;
		end else if (rdTake) begin
			rvalid_ff <= 1'b1;
			rdata_ff <= {24'h00_0000, rdByte};
			rresp_ff <= rdHit ? lan_regs_pkg::RESP_OKAY : lan_regs_pkg::RESP_SLVERR;
		end else if (s_axi_rready) begin
			rvalid_ff <= 1'b0;
		end
	end

	// ========================================
	// Checks
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!nrst);

	sequence s_write(logic [15:0] idx);
		wrEn && wrIdx == idx;
	endsequence

	sequence s_read(logic [15:0] idx);
		rdTake && rdIdx == idx;
	endsequence

	chk_set_ladder: assert property (s_write(lan_regs_pkg::IDX_SET_LEVEL) |-> ##2
		cfgOut.setTenthsPpm == lan_regs_pkg::lan_ppm_tenths($past(wrByte[7:4], 2)))
		else $error("set level decode wrong");
	chk_clear_ladder: assert property (s_write(lan_regs_pkg::IDX_CLEAR_LEVEL) |-> ##2
		cfgOut.clearTenthsPpm == lan_regs_pkg::lan_ppm_tenths($past(wrByte[7:4], 2)))
		else $error("clear level decode wrong");
	chk_timer_enable: assert property (s_write(lan_regs_pkg::IDX_TIMER_CTL) |-> ##2
		cfgOut.timerOn == $past(wrByte[1], 2))
		else $error("timer enable not applied");
	chk_count_code: assert property (s_read(lan_regs_pkg::IDX_WRITE_COUNT) |=>
		s_axi_rdata[7:0] == 8'h3F >> (2 * (3 - $past(writeCount_ff))))
		else $error("write count code illegal");
	chk_burn_start: assert property ((s_write(lan_regs_pkg::IDX_BURN_CMD)
		and wrByte == lan_regs_pkg::BURN_KEY && nvmState_ff == lan_regs_pkg::LAN_NVM_IDLE)
		|=> burnStart ##1 !burnStart && nvmState_ff == lan_regs_pkg::LAN_NVM_BURN)
		else $error("burn did not start");
	chk_reload_start: assert property ((reloadReq && !burnReq
		&& nvmState_ff == lan_regs_pkg::LAN_NVM_IDLE) |=> reloadStart && readyByte == 8'h00)
		else $error("reload did not start");
	chk_extend_flag: assert property (s_write(lan_regs_pkg::IDX_EXTEND_CTL) |-> ##2
		cfgOut.extendOn == $past(wrByte[5], 2))
		else $error("extend enable not applied");
	chk_extend_top: assert property (s_write(lan_regs_pkg::IDX_EXTEND_LO + 16'h0003) |-> ##2
		cfgOut.extendLen[28:24] == $past(wrByte[4:0], 2))
		else $error("extend top byte wrong");
	chk_ready_code: assert property (rdTake && rdIdx[7:0] == 8'hFE
		&& nvmState_ff == lan_regs_pkg::LAN_NVM_IDLE |=> s_axi_rdata[7:0] == 8'h0F)
		else $error("ready byte not 0x0F");
	chk_gate_off: assert property (!gate_ff ##1 !gate_ff |-> outEnGated == '0)
		else $error("outputs not gated off");
	chk_summary_bits: assert property (alarmEvent.pll[1] |=> summary[2]
		&& flags_ff.pll[1])
		else $error("summary bit missing");

endmodule : lan_ctrl_regs

/* sim/lan_ctrl_regs_tb.sv */
// Purpose: Self-checking bench for the lock alarm / NVM control register slice
// Assumes: AXI4-Lite master changes signals by non-blocking assignment after a rising edge
// Notes: Byte address is four times the register index; every bus wait is bounded
module lan_ctrl_regs_tb;
	timeunit 1ns;
	timeprecision 1ps;

	// ========================================
	// Stimulus and observed signals
	logic clk_sys = 1'b0;
	logic nrst = 1'b0;
	logic [lan_regs_pkg::ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [31:0] s_axi_wdata = '0, s_axi_rdata;
	logic [3:0] s_axi_wstrb = 4'h1;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	lan_regs_pkg::lan_alarm_t alarmEvent = '0;
	logic burnDone = 1'b0, reloadDone = 1'b0, burnStart, reloadStart;
	logic [9:0] outEnReq = 10'h2A5, outEnGated;
	lan_regs_pkg::lan_cfg_t cfgOut;
	int miscompares = 0, samples_checked = 0, burnSeen = 0, reloadSeen = 0;
	logic [16:0] ladder [0:10] = '{17'h00001, 17'h00003, 17'h0000A, 17'h0001E, 17'h00064,
		17'h0012C, 17'h003E8, 17'h00BB8, 17'h02710, 17'h07530, 17'h186A0};
	logic [7:0] cntCode [1:3] = '{8'h03, 8'h0F, 8'h3F};

	always #2.5 clk_sys = ~clk_sys;

	// Start pulses last one cycle, so they are counted rather than polled
	always @(posedge clk_sys) begin
		if (burnStart === 1'b1) burnSeen++;
		if (reloadStart === 1'b1) reloadSeen++;
	end

	lan_ctrl_regs #(.NUM_OUT(10)) u_lan_ctrl_regs (.clk_sys(clk_sys), .nrst(nrst),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .alarmEvent(alarmEvent),
		.burnDone(burnDone), .reloadDone(reloadDone), .outEnReq(outEnReq), .cfgOut(cfgOut),
		.burnStart(burnStart), .reloadStart(reloadStart), .outEnGated(outEnGated));

	// ========================================
	// Report and compare
	task automatic give_verdict();
		$display("compares %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : give_verdict

	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk

	task automatic timeout();
		miscompares++;
		$display("unexpected bus answer expected response seen none");
		give_verdict();
	endtask : timeout

	// ========================================
	// AXI4-Lite master; starts one edge after the previous transfer released
	task automatic axi_wr(input logic [15:0] idx, input logic [7:0] val, output logic [1:0] resp);
		int n;
		@(posedge clk_sys);
		s_axi_awaddr <= {idx, 2'h0};
		s_axi_wdata <= {24'h000000, val};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (n = 0; n < 100; n++) begin
			@(posedge clk_sys);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid === 1'b1) break;
		end
		if (n == 100) timeout();
		resp = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask : axi_wr

	task automatic axi_rd(input logic [15:0] idx, output logic [31:0] data,
		output logic [1:0] resp);
		int n;
		@(posedge clk_sys);
		s_axi_araddr <= {idx, 2'h0};
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (n = 0; n < 100; n++) begin
			@(posedge clk_sys);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid === 1'b1) break;
		end
		if (n == 100) timeout();
		data = s_axi_rdata;
		resp = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask : axi_rd

	task automatic wr(input logic [15:0] idx, input logic [7:0] val);
		logic [1:0] resp;
		axi_wr(idx, val, resp);
		chk($sformatf("bresp %h", idx), {30'h0, lan_regs_pkg::RESP_OKAY}, {30'h0, resp});
	endtask : wr

	task automatic rd(input logic [15:0] idx, input logic [7:0] exp);
		logic [31:0] data;
		logic [1:0] resp;
		axi_rd(idx, data, resp);
		chk($sformatf("rdata %h", idx), {24'h000000, exp}, data);
		chk($sformatf("rresp %h", idx), {30'h0, lan_regs_pkg::RESP_OKAY}, {30'h0, resp});
	endtask : rd

	task automatic pulse_done(input bit burn);
		@(posedge clk_sys);
		if (burn) burnDone <= 1'b1;
		else reloadDone <= 1'b1;
		@(posedge clk_sys);
		burnDone <= 1'b0;
		reloadDone <= 1'b0;
	endtask : pulse_done

	function automatic logic [31:0] lvl(input int c);
		lvl = (c <= 10) ? {15'h0, ladder[c]} : 32'h0;
	endfunction : lvl

	// ========================================
	// Test sequence
	initial begin
		int i;
		int base;
		logic [31:0] data;
		logic [1:0] resp;
		repeat (2) @(posedge clk_sys);
		nrst <= 1'b1;
		rd(16'h00FE, 8'h00);
		pulse_done(1'b0);
		rd(16'h00FE, 8'h0F);
		rd(16'h05FE, 8'h0F);
		rd(16'h7FFE, 8'h0F);
		chk("extendOn", 32'h1, {31'h0, cfgOut.extendOn});
		chk("outEnGated", 32'h2A5, {22'h0, outEnGated});
		// Both ladders at once, clear level walks the codes backwards
		for (i = 0; i < 12; i++) begin
			wr(16'h009E, 8'(i << 4));
			wr(16'h00A0, 8'((11 - i) << 4));
			repeat (2) @(posedge clk_sys);
			chk("setTenthsPpm", lvl(i), {15'h0, cfgOut.setTenthsPpm});
			chk("clearTenthsPpm", lvl(11 - i), {15'h0, cfgOut.clearTenthsPpm});
			chk("setValid", {31'h0, i <= 10}, {31'h0, cfgOut.setValid});
			chk("clearValid", {31'h0, (11 - i) <= 10}, {31'h0, cfgOut.clearValid});
			rd(16'h009E, 8'(i << 4));
		end
		// Lane 0 disabled: answered but nothing stored
		s_axi_wstrb <= 4'h0;
		wr(16'h009E, 8'h50);
		s_axi_wstrb <= 4'h1;
		rd(16'h009E, 8'hB0);
		wr(16'h00A2, 8'h02);
		repeat (2) @(posedge clk_sys);
		chk("timerOn", 32'h1, {31'h0, cfgOut.timerOn});
		wr(16'h00A2, 8'hFD);
		repeat (2) @(posedge clk_sys);
		chk("timerOn", 32'h0, {31'h0, cfgOut.timerOn});
		wr(16'h00E5, 8'hDF);
		repeat (2) @(posedge clk_sys);
		chk("extendOn", 32'h0, {31'h0, cfgOut.extendOn});
		wr(16'h00EA, 8'h78);
		wr(16'h00EB, 8'h56);
		wr(16'h00EC, 8'h34);
		wr(16'h00ED, 8'hFF);
		wr(16'h00A9, 8'h11);
		wr(16'h00AA, 8'h22);
		wr(16'h00AB, 8'h33);
		wr(16'h00AC, 8'hE4);
		repeat (2) @(posedge clk_sys);
		chk("extendLen", 32'h1F345678, {3'h0, cfgOut.extendLen});
		chk("clearDelay", 32'h04332211, {3'h0, cfgOut.clearDelay});
		rd(16'h00A9, 8'h11);
		rd(16'h00AC, 8'h04);
		rd(16'h00EA, 8'h78);
		rd(16'h00ED, 8'h1F);
		// A wrong key must not burn
		wr(16'h00E3, 8'h55);
		repeat (2) @(posedge clk_sys);
		chk("burnStart", 32'h0, burnSeen);
		for (i = 1; i < 4; i++) begin
			wr(16'h00E3, 8'hC7);
			repeat (2) @(posedge clk_sys);
			chk("burnStart", i, burnSeen);
			rd(16'h00FE, 8'h00);
			pulse_done(1'b1);
			rd(16'h00E2, cntCode[i]);
		end
		axi_wr(16'h00E2, 8'h00, resp);
		chk("bresp ro", {30'h0, lan_regs_pkg::RESP_SLVERR}, {30'h0, resp});
		rd(16'h00E2, 8'h3F);
		base = reloadSeen;
		wr(16'h00E4, 8'h01);
		repeat (2) @(posedge clk_sys);
		chk("reloadStart", base + 1, reloadSeen);
		rd(16'h00E4, 8'h01);
		rd(16'h00FE, 8'h00);
		pulse_done(1'b0);
		rd(16'h00FE, 8'h0F);
		axi_rd(16'h0050, data, resp);
		chk("unmapped rresp", {30'h0, lan_regs_pkg::RESP_SLVERR}, {30'h0, resp});
		chk("unmapped rdata", 32'h0, data);
		@(posedge clk_sys);
		alarmEvent <= 24'hFF0022;
		@(posedge clk_sys);
		alarmEvent <= '0;
		rd(16'h00F6, 8'h05);
		rd(16'h00F9, 8'h22);
		rd(16'h00F6, 8'h01);
		rd(16'h00F7, 8'h37);
		rd(16'h00F6, 8'h00);
		// Event still high while the read clears: the event must win
		alarmEvent <= 24'h00A500;
		rd(16'h00F8, 8'hA5);
		alarmEvent <= '0;
		rd(16'h00F6, 8'h02);
		rd(16'h00F8, 8'hA5);
		rd(16'h00F6, 8'h00);
		wr(16'h0102, 8'hFE);
		repeat (3) @(posedge clk_sys);
		chk("outEnGated", 32'h0, {22'h0, outEnGated});
		wr(16'h0102, 8'h01);
		repeat (3) @(posedge clk_sys);
		chk("outEnGated", 32'h2A5, {22'h0, outEnGated});
		outEnReq <= 10'h15A;
		repeat (2) @(posedge clk_sys);
		chk("outEnGated", 32'h15A, {22'h0, outEnGated});
		give_verdict();
	end

endmodule : lan_ctrl_regs_tb
